// ===== logic/gig_mgmt_defs.svh
// Constants for the gigabit control/status and extended access block.
// Assumes inclusion by bare name from every design module file.
`ifndef GIG_MGMT_DEFS_SVH
`define GIG_MGMT_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_GIG_CTRL 5'h09
`define OFS_GIG_STAT 5'h0A
`define OFS_MMD_CTRL 5'h0D
`define OFS_MMD_DATA 5'h0E
// ----------------------------------------
// Field positions
// ----------------------------------------
`define GC_TEST_HI 15
`define GC_TEST_LO 13
`define GC_MAN_EN 12
`define GC_MAN_VAL 11
`define GC_PORT 10
`define GC_ADV_FULL 9
`define GC_ADV_HALF 8
`define GC_TDR 7
`define GS_FAULT 15
`define GS_ROLE 14
`define GS_LOC_OK 13
`define GS_REM_OK 12
`define GS_LP_FULL 11
`define GS_LP_HALF 10
`define GS_CNT_HI 7
`define MC_FN_HI 15
`define MC_FN_LO 14
`define MC_DEV_HI 4
// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define FN_ADDR 2'h0
`define FN_DATA 2'h1
`define FN_INC_RW 2'h2
`define FN_INC_W 2'h3
`define GIG_CTRL_RST 16'h0300
`define ZERO16 16'h0000
`define TEST_REP 3'h6
`define TEST_PULSE 3'h7
`define PULSE_LAST 6'h3F
`define REP_WORD 4'h1
`define REP_LAST 2'h3
`define CNT_MAX 8'hFF
`define ONE16 16'h0001
`endif

// ===== logic/gig_mgmt_pkg.sv
// Types for the gigabit control/status and extended access block.
// Assumes nothing beyond a SystemVerilog compiler.
package gig_mgmt_pkg;
    // Test pattern generator state
    typedef struct packed {
        logic [5:0] pos;
        logic sym;
    } pat_state_t;
    // Idle error counter state
    typedef struct packed {
        logic [7:0] count;
    } cnt_state_t;
    // Register bank state
    typedef struct packed {
        logic [2:0] test_mode;
        logic man_en;
        logic man_val;
        logic multi_port;
        logic adv_full;
        logic adv_half;
        logic tdr_auto;
        logic strap_done;
        logic fault;
        logic role_master;
        logic link_prev;
        logic tdr_start;
        logic [1:0] fn;
        logic [4:0] dev;
        logic [31:0][15:0] mmd_addr;
        logic [15:0] cur_addr;
        logic [15:0] rdata;
        logic rvalid;
        logic mmd_wr;
        logic mmd_rd;
        logic [15:0] mmd_wdata;
    } bank_state_t;
endpackage

// ===== logic/test_pattern_gen.sv
// Transmit test symbol source for the repeating test modes.
// Assumes mode comes from a register in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "gig_mgmt_defs.svh"
module test_pattern_gen (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [2:0] mode,
    output logic sym
);
    gig_mgmt_pkg::pat_state_t st; // Current state
    gig_mgmt_pkg::pat_state_t next_st; // Next state

    // Position walks the pattern; sym is the bit at that position
    always_comb begin
        next_st = st;
        next_st.pos = st.pos + 6'h01;
        case (mode)
            `TEST_PULSE: begin
                next_st.sym = (st.pos == 6'h00);
            end
            `TEST_REP: begin
                next_st.sym = 1'(`REP_WORD >> (`REP_LAST - st.pos[1:0]));
            end
            default: begin // No pattern outside modes 6 and 7
                next_st.sym = 1'b0;
                next_st.pos = 6'h00;
            end
        endcase
        if (mode == `TEST_REP && st.pos[1:0] == `REP_LAST) begin
            next_st.pos = 6'h00;
        end
        if (mode == `TEST_PULSE && st.pos == `PULSE_LAST) begin
            next_st.pos = 6'h00;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sym = st.sym;
endmodule
`default_nettype wire

// ===== logic/idle_err_counter.sv
// Saturating count of gigabit idle errors.
// Assumes one event pulse per detected error.
`timescale 1ns/1ps
`default_nettype none
`include "gig_mgmt_defs.svh"
module idle_err_counter (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic err_evt,
    output logic [7:0] count
);
    gig_mgmt_pkg::cnt_state_t st; // Current count
    gig_mgmt_pkg::cnt_state_t next_st; // Next count

    // Count up, hold at full scale so no wrap hides errors
    always_comb begin
        next_st = st;
        if (err_evt && st.count != `CNT_MAX) begin
            next_st.count = st.count + 8'h01;
        end
    end

    // Counter register, zero at reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;
endmodule
`default_nettype wire

// ===== logic/gig_ctrl_status_mmd_access.sv
// Gigabit control/status registers and indirect extended register window.
// Assumes the management frame decoder presents one-cycle read and write
// strobes with a register number, and that the extended register store
// answers mmd_rdata combinationally for mmd_dev_sel and mmd_reg_addr.
`timescale 1ns/1ps
`default_nettype none
`include "gig_mgmt_defs.svh"

// Overview of operation
// - Three-bit field selects normal or seven test modes
// - Mode 7 pulse plus 63 zeros; mode 6 0001
// - Manual enable takes role from manual value bit
// - Manual value one means master, zero slave
// - Port type bit marks multi-port or single-port
// - Advertise bits reset to one, then load straps once
// - Auto cable test launches after each link drop
// - Role fault flag latches high, clears on read
// - Status bit 14 shows resolved master role
// - Bits 13 and 12 show receiver health
// - Bits 11 and 10 show partner gigabit abilities
// - Low status byte is idle error counter
// - Device select steers window accesses
// - Window reaches address register for function 00
// - Control resets 0x300, others reset zero
module gig_ctrl_status_mmd_access (
    input wire logic ref_clk,
    input wire logic arst_n,
    // Management register port
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Straps and link-side status
    input wire logic strap_adv_full,
    input wire logic strap_adv_half,
    input wire logic auto_role_master,
    input wire logic role_fault_evt,
    input wire logic local_rx_ok,
    input wire logic remote_rx_ok,
    input wire logic partner_gig_full,
    input wire logic partner_gig_half,
    input wire logic idle_err_evt,
    input wire logic link_up,
    // Controls to the transceiver
    output logic [2:0] test_mode,
    output logic tx_test_sym,
    output logic role_master,
    output logic multi_port,
    output logic adv_gig_full,
    output logic adv_gig_half,
    output logic tdr_start,
    // Extended register store
    output logic [4:0] mmd_dev_sel,
    output logic [15:0] mmd_reg_addr,
    output logic mmd_wr,
    output logic mmd_rd,
    output logic [15:0] mmd_wdata,
    input wire logic [15:0] mmd_rdata
);
    // ----------------------------------------
    // State and helpers
    // ----------------------------------------
    gig_mgmt_pkg::bank_state_t st; // Current state
    gig_mgmt_pkg::bank_state_t next_st; // Next state
    logic [7:0] idle_count; // From idle error counter
    logic [15:0] ctrl_word; // Control register image
    logic [15:0] stat_word; // Status register image
    logic [15:0] mmd_ctrl_word; // Access control image
    logic win_rd; // Data window read this cycle
    logic win_wr; // Data window write this cycle

    // Whether a data access bumps the address
    // Function 10 steps on reads and writes alike
    // Function 11 steps on writes only
    // Functions 00 and 01 never step
    // Shared by the read and the write path
    function automatic logic addr_step(input logic [1:0] fn, input logic is_wr);
        begin
            case (fn)
                `FN_INC_RW: addr_step = 1'b1;
                `FN_INC_W: addr_step = is_wr;
                default: addr_step = 1'b0;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    // Repeating test symbols
    test_pattern_gen u_pat (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .mode(st.test_mode),
        .sym(tx_test_sym)
    );

    // Idle error count
    idle_err_counter u_cnt (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .err_evt(idle_err_evt),
        .count(idle_count)
    );

    // ----------------------------------------
    // Read images
    // ----------------------------------------
    // Assemble register words; reserved bits read zero
    // Control image mirrors the stored fields
    // Status image mixes latched and live bits
    // Live bits are sampled only when a read lands
    // Access control image keeps bits 13 to 5 clear
    always_comb begin
        ctrl_word = `ZERO16;
        ctrl_word[`GC_TEST_HI:`GC_TEST_LO] = st.test_mode;
        ctrl_word[`GC_MAN_EN] = st.man_en;
        ctrl_word[`GC_MAN_VAL] = st.man_val;
        ctrl_word[`GC_PORT] = st.multi_port;
        ctrl_word[`GC_ADV_FULL] = st.adv_full;
        ctrl_word[`GC_ADV_HALF] = st.adv_half;
        ctrl_word[`GC_TDR] = st.tdr_auto;
        stat_word = `ZERO16;
        stat_word[`GS_FAULT] = st.fault;
        stat_word[`GS_ROLE] = st.role_master;
        stat_word[`GS_LOC_OK] = local_rx_ok;
        stat_word[`GS_REM_OK] = remote_rx_ok;
        stat_word[`GS_LP_FULL] = partner_gig_full;
        stat_word[`GS_LP_HALF] = partner_gig_half;
        stat_word[`GS_CNT_HI:0] = idle_count;
        mmd_ctrl_word = `ZERO16;
        mmd_ctrl_word[`MC_FN_HI:`MC_FN_LO] = st.fn;
        mmd_ctrl_word[`MC_DEV_HI:0] = st.dev;
    end

    // Data window strobes, only outside address mode
    // Address mode touches only the per-device pointer
    // So the store sees no strobe in that mode
    always_comb begin
        win_rd = reg_rd && reg_addr == `OFS_MMD_DATA && st.fn != `FN_ADDR;
        win_wr = reg_wr && reg_addr == `OFS_MMD_DATA && st.fn != `FN_ADDR;
    end

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    // Pulses default low, so each lasts one cycle
    // Read valid follows the read strobe directly
    // Later assignments in this process take priority
    always_comb begin
        next_st = st;
        next_st.tdr_start = 1'b0;
        next_st.mmd_wr = 1'b0;
        next_st.mmd_rd = 1'b0;
        next_st.rvalid = reg_rd;

        // Load advertise defaults from straps once after reset
        // A control write in the same cycle overrides them
        // Straps are never looked at again afterwards
        if (!st.strap_done) begin
            next_st.strap_done = 1'b1;
            next_st.adv_full = strap_adv_full;
            next_st.adv_half = strap_adv_half;
        end

        // Role: manual value overrides automatic resolution
        // Registered, so the role lags its inputs a cycle
        if (st.man_en) begin
            next_st.role_master = st.man_val;
        end else begin
            next_st.role_master = auto_role_master;
        end

        // Link drop launches cable test when enabled
        // Falling edge found against last cycle's link level
        // Link level after reset is down, so no false edge
        next_st.link_prev = link_up;
        if (st.link_prev && !link_up && st.tdr_auto) begin
            next_st.tdr_start = 1'b1;
        end

        // Register writes
        // Status offset is read-only, falls to default
        if (reg_wr) begin
            case (reg_addr)
                `OFS_GIG_CTRL: begin
                    next_st.test_mode = reg_wdata[`GC_TEST_HI:`GC_TEST_LO];
                    next_st.man_en = reg_wdata[`GC_MAN_EN];
                    next_st.man_val = reg_wdata[`GC_MAN_VAL];
                    next_st.multi_port = reg_wdata[`GC_PORT];
                    next_st.adv_full = reg_wdata[`GC_ADV_FULL];
                    next_st.adv_half = reg_wdata[`GC_ADV_HALF];
                    next_st.tdr_auto = reg_wdata[`GC_TDR];
                end
                `OFS_MMD_CTRL: begin
                    next_st.fn = reg_wdata[`MC_FN_HI:`MC_FN_LO];
                    next_st.dev = reg_wdata[`MC_DEV_HI:0];
                end
                `OFS_MMD_DATA: begin
                    if (st.fn == `FN_ADDR) begin
                        next_st.mmd_addr[st.dev] = reg_wdata;
                    end else begin
                        next_st.mmd_wr = 1'b1;
                        next_st.mmd_wdata = reg_wdata;
                    end
                end
                default: begin // Other offsets ignore writes
                end
            endcase
        end

        // Register reads, answered one cycle later
        // Store data is taken in the cycle of the strobe
        // Answer holds until the next read replaces it
        case (reg_addr)
            `OFS_GIG_CTRL: next_st.rdata = ctrl_word;
            `OFS_GIG_STAT: next_st.rdata = stat_word;
            `OFS_MMD_CTRL: next_st.rdata = mmd_ctrl_word;
            `OFS_MMD_DATA: begin
                if (st.fn == `FN_ADDR) begin
                    next_st.rdata = st.cur_addr;
                end else begin
                    next_st.rdata = mmd_rdata;
                end
            end
            default: next_st.rdata = `ZERO16; // Unmapped reads zero
        endcase
        if (!reg_rd) begin
            next_st.rdata = st.rdata; // Hold last answer
        end
        if (win_rd) begin
            next_st.mmd_rd = 1'b1;
        end

        // Post-increment of the selected device address
        // Only the selected device's pointer moves
        // Pointer wraps from the top back to zero
        if ((win_rd && addr_step(st.fn, 1'b0)) || (win_wr && addr_step(st.fn, 1'b1))) begin
            next_st.mmd_addr[st.dev] = st.mmd_addr[st.dev] + `ONE16;
        end

        // Fault flag: read clears, new fault wins
        // Read answer still shows the flag before clearing
        if (reg_rd && reg_addr == `OFS_GIG_STAT) begin
            next_st.fault = 1'b0;
        end
        if (role_fault_evt) begin
            next_st.fault = 1'b1;
        end

        // Address presented to the extended store
        // Taken from next state so it tracks select changes
        // Store answers combinationally at this address
        next_st.cur_addr = next_st.mmd_addr[next_st.dev];
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Reset to documented values; straps loaded after release
    // Advertise bits come from the control reset word
    // Everything else, including pointers, clears to zero
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            st.adv_full <= 1'(`GIG_CTRL_RST >> `GC_ADV_FULL);
            st.adv_half <= 1'(`GIG_CTRL_RST >> `GC_ADV_HALF);
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs, all from flip-flops
    // ----------------------------------------
    // No logic between state and pins
    // Keeps output timing free of decode paths
    // Store strobes and data move together
    // Device select and pointer share one update
    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;
    assign test_mode = st.test_mode;
    assign role_master = st.role_master;
    assign multi_port = st.multi_port;
    assign adv_gig_full = st.adv_full;
    assign adv_gig_half = st.adv_half;
    assign tdr_start = st.tdr_start;
    assign mmd_dev_sel = st.dev;
    assign mmd_reg_addr = st.cur_addr;
    assign mmd_wr = st.mmd_wr;
    assign mmd_rd = st.mmd_rd;
    assign mmd_wdata = st.mmd_wdata;
endmodule
`default_nettype wire

// ===== verif/gig_mgmt_asserts.sv
// Port checker for the gigabit control/status and extended window block.
// Assumes it is bound onto gig_ctrl_status_mmd_access, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module gig_mgmt_checker (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic auto_role_master,
    input wire logic role_fault_evt,
    input wire logic local_rx_ok,
    input wire logic remote_rx_ok,
    input wire logic partner_gig_full,
    input wire logic partner_gig_half,
    input wire logic link_up,
    input wire logic [2:0] test_mode,
    input wire logic tx_test_sym,
    input wire logic role_master,
    input wire logic multi_port,
    input wire logic adv_gig_full,
    input wire logic adv_gig_half,
    input wire logic tdr_start,
    input wire logic [4:0] mmd_dev_sel,
    input wire logic [15:0] mmd_reg_addr,
    input wire logic mmd_wr,
    input wire logic mmd_rd,
    input wire logic [15:0] mmd_wdata
);
    // ----------------------------------------
    // Strobe sequences and properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence s_ctrl_wr; reg_wr && reg_addr == 5'h09; endsequence
    sequence s_stat_rd; reg_rd && reg_addr == 5'h0A; endsequence
    property p_mode; s_ctrl_wr |=> test_mode == $past(reg_wdata[15:13]); endproperty
    a_mode: assert property (p_mode) else $error("test mode not taken");
    property p_sym6; (test_mode == 3'h6) [*8] |-> tx_test_sym == $past(tx_test_sym, 4) &&
        $countones({tx_test_sym, $past(tx_test_sym), $past(tx_test_sym, 2), $past(tx_test_sym, 3)}) == 1; endproperty
    a_sym6: assert property (p_sym6) else $error("mode six stream wrong");
    property p_role; s_ctrl_wr |=> ##1 role_master ==
        ($past(reg_wdata[12], 2) ? $past(reg_wdata[11], 2) : $past(auto_role_master)); endproperty
    a_role: assert property (p_role) else $error("role wrong");
    property p_ctrl; s_ctrl_wr |=> {multi_port, adv_gig_full, adv_gig_half} == $past(reg_wdata[10:8]); endproperty
    a_ctrl: assert property (p_ctrl) else $error("port or advert bits wrong");
    property p_tdr; tdr_start |-> $past(link_up, 2) && !$past(link_up); endproperty
    a_tdr: assert property (p_tdr) else $error("cable test start without link drop");
    property p_fset; role_fault_evt ##1 s_stat_rd |=> reg_rdata[15]; endproperty
    a_fset: assert property (p_fset) else $error("fault flag not latched");
    property p_fclr; (reg_rd && reg_addr == 5'h0A && !role_fault_evt) ##1 s_stat_rd |=> !reg_rdata[15]; endproperty
    a_fclr: assert property (p_fclr) else $error("fault flag not cleared");
    property p_stat; s_stat_rd |=> reg_rdata[14:8] == {$past(role_master), $past(local_rx_ok),
        $past(remote_rx_ok), $past(partner_gig_full), $past(partner_gig_half), 2'h0}; endproperty
    a_stat: assert property (p_stat) else $error("status fields wrong");
    property p_dev; reg_wr && reg_addr == 5'h0D |=> mmd_dev_sel == $past(reg_wdata[4:0]); endproperty
    a_dev: assert property (p_dev) else $error("device select wrong");
    property p_mwr; mmd_wr |-> $past(reg_wr) && $past(reg_addr) == 5'h0E && mmd_wdata == $past(reg_wdata); endproperty
    a_mwr: assert property (p_mwr) else $error("window write wrong");
    property p_mrd; mmd_rd |-> $past(reg_rd) && $past(reg_addr) == 5'h0E; endproperty
    a_mrd: assert property (p_mrd) else $error("window read strobe wrong");
    property p_hold; !$past(reg_wr) && !$past(reg_rd) |-> $stable(mmd_reg_addr) && $stable(mmd_dev_sel); endproperty
    a_hold: assert property (p_hold) else $error("window address moved idle");
endmodule
bind gig_ctrl_status_mmd_access gig_mgmt_checker i_chk (.*);
`default_nettype wire

// ===== verif/mmd_store_model.sv
// Behavioural extended register store behind the window.
// Assumes strobes and address come from the block on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module mmd_store_model (
    input wire logic ref_clk,
    input wire logic [4:0] dev_sel,
    input wire logic [15:0] reg_addr,
    input wire logic wr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata
);
    logic [15:0] mem [bit [20:0]]; // Written words by device and address
    logic [20:0] prev_key = 21'h000000; // Place one cycle back
    logic tick = 1'b0; // Wakes the answer after a store
    // Pulse follows the address step, so store at the place one cycle back
    always @(posedge ref_clk) begin
        if (wr === 1'b1) begin
            mem[prev_key] = wdata;
        end
        prev_key <= {dev_sel, reg_addr};
        tick = ~tick;
    end
    // Answer at once; unwritten places give a fill word
    always @(dev_sel, reg_addr, tick) begin
        rdata = mem.exists({dev_sel, reg_addr}) ? mem[{dev_sel, reg_addr}] : ~reg_addr ^ {dev_sel, 11'h000};
    end
endmodule
`default_nettype wire

// ===== verif/gig_ctrl_status_mmd_access_tb.sv
// Self-checking bench for the gigabit control/status block.
// Assumes design, checker and store model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module gig_ctrl_status_mmd_access_tb;
    // ----------------------------------------
    // Stimulus, wiring and helpers
    // ----------------------------------------
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, auto_role_master = 1'b0, role_fault_evt = 1'b0;
    logic idle_err_evt = 1'b0, link_up = 1'b0, strap_adv_full = 1'b1, strap_adv_half = 1'b0;
    logic [3:0] live = 4'h0; // Local, remote, partner full, partner half
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata, mmd_reg_addr, mmd_wdata, mmd_rdata;
    logic reg_rvalid, tx_test_sym, role_master, multi_port, adv_gig_full, adv_gig_half, tdr_start, mmd_wr;
    logic [2:0] test_mode;
    logic [4:0] mmd_dev_sel;
    int miscompares = 0;
    int checks_done = 0;
    int tdr_cnt = 0;
    logic [15:0] expq [$]; // Expected read answers, oldest first
    logic [31:0] seed = 32'h00000025; // Xorshift state
    always #10 ref_clk = ~ref_clk; // 50 MHz
    gig_ctrl_status_mmd_access i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .strap_adv_full(strap_adv_full), .strap_adv_half(strap_adv_half), .auto_role_master(auto_role_master),
        .role_fault_evt(role_fault_evt), .local_rx_ok(live[3]), .remote_rx_ok(live[2]),
        .partner_gig_full(live[1]), .partner_gig_half(live[0]), .idle_err_evt(idle_err_evt), .link_up(link_up),
        .test_mode(test_mode), .tx_test_sym(tx_test_sym), .role_master(role_master), .multi_port(multi_port),
        .adv_gig_full(adv_gig_full), .adv_gig_half(adv_gig_half), .tdr_start(tdr_start),
        .mmd_dev_sel(mmd_dev_sel), .mmd_reg_addr(mmd_reg_addr), .mmd_wr(mmd_wr), .mmd_rd(),
        .mmd_wdata(mmd_wdata), .mmd_rdata(mmd_rdata));
    mmd_store_model i_store (.ref_clk(ref_clk), .dev_sel(mmd_dev_sel), .reg_addr(mmd_reg_addr), .wr(mmd_wr),
        .wdata(mmd_wdata), .rdata(mmd_rdata));
    // Compare and count
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    // One register cycle, strobe held across one rising edge
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        expq.push_back(exp);
        acc(1'b0, a, 16'h0000);
    endtask
    // Sample the test stream and check its ones and period
    task automatic pattern(input logic [2:0] m, input int p, input int ones);
        logic [127:0] v;
        acc(1'b1, 5'h09, {m, 13'h0300});
        repeat (4) @(negedge ref_clk);
        for (int i = 0; i < 128; i++) begin
            v[i] = tx_test_sym;
            @(negedge ref_clk);
        end
        chk("test ones", 16'($countones(v)), 16'(ones));
        for (int i = 0; i + p < 128; i++) chk("test period", 16'(v[i]), 16'(v[i + p]));
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Read answer watcher: oldest note against each answer
    always @(negedge ref_clk) begin
        if (reg_rvalid === 1'b1) begin
            if (expq.size() == 0) begin
                miscompares++;
                $display("[FAIL] read answer expected none seen %h", reg_rdata);
            end else begin
                chk("read data", reg_rdata, expq.pop_front());
            end
        end
    end
    always @(posedge ref_clk) if (tdr_start === 1'b1) tdr_cnt++;
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        $display("watchdog expired");
        results();
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        logic [15:0] r;
        logic [15:0] d;
        repeat (20) @(negedge ref_clk);
        chk("advert in reset", 16'({adv_gig_full, adv_gig_half}), 16'h0003);
        arst_n = 1'b1;
        rd(5'h09, 16'h0200);
        rd(5'h0A, 16'h0000);
        rd(5'h0D, 16'h0000);
        rd(5'h0E, 16'h0000);
        rd(5'h03, 16'h0000);
        $display("test reset done");
        for (int m = 0; m < 8; m++) begin
            r = rnd();
            d = {m[2:0], r[12:0]};
            auto_role_master = r[15];
            acc(1'b1, 5'h09, d);
            rd(5'h09, d & 16'hFF80);
            chk("test mode", 16'(test_mode), 16'(m));
            chk("role", 16'(role_master), 16'(d[12] ? d[11] : r[15]));
            chk("ctrl bits", 16'({multi_port, adv_gig_full, adv_gig_half}), 16'(d[10:8]));
        end
        pattern(3'h7, 64, 2);
        pattern(3'h6, 4, 32);
        pattern(3'h0, 1, 0);
        $display("test control done");
        live = 4'hA;
        auto_role_master = 1'b1;
        idle_err_evt = 1'b1;
        repeat (3) @(negedge ref_clk);
        idle_err_evt = 1'b0;
        role_fault_evt = 1'b1;
        @(negedge ref_clk);
        role_fault_evt = 1'b0;
        rd(5'h0A, 16'hE803);
        rd(5'h0A, 16'h6803);
        idle_err_evt = 1'b1;
        repeat (300) @(negedge ref_clk);
        idle_err_evt = 1'b0;
        rd(5'h0A, 16'h68FF);
        link_up = 1'b1;
        acc(1'b1, 5'h09, 16'h0380);
        link_up = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("cable test", 16'(tdr_cnt), 16'h0001);
        link_up = 1'b1;
        acc(1'b1, 5'h09, 16'h0300);
        link_up = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("cable test", 16'(tdr_cnt), 16'h0001);
        $display("test status done");
        acc(1'b1, 5'h0D, 16'h001F);
        acc(1'b1, 5'h0E, 16'h0100);
        acc(1'b1, 5'h0D, 16'h401F);
        acc(1'b1, 5'h0E, 16'hA5A5);
        rd(5'h0E, 16'hA5A5);
        rd(5'h0E, 16'hA5A5);
        acc(1'b1, 5'h0D, 16'h801F);
        rd(5'h0E, 16'hA5A5);
        acc(1'b1, 5'h0E, 16'h1234);
        acc(1'b1, 5'h0D, 16'h001F);
        rd(5'h0E, 16'h0102);
        acc(1'b1, 5'h0D, 16'hC01F);
        rd(5'h0E, ~16'h0102 ^ 16'hF800);
        acc(1'b1, 5'h0E, 16'h5555);
        acc(1'b1, 5'h0D, 16'h001F);
        rd(5'h0E, 16'h0103);
        acc(1'b1, 5'h0E, 16'h0101);
        acc(1'b1, 5'h0D, 16'h801F);
        rd(5'h0E, 16'h1234);
        rd(5'h0E, 16'h5555);
        acc(1'b1, 5'h0D, 16'h0003);
        rd(5'h0E, 16'h0000);
        acc(1'b1, 5'h0D, 16'h4003);
        rd(5'h0E, ~16'h0000 ^ 16'h1800);
        rd(5'h0D, 16'h4003);
        acc(1'b1, 5'h0D, 16'h001F);
        rd(5'h0E, 16'h0103);
        repeat (3) @(negedge ref_clk);
        chk("pending reads", 16'(expq.size()), 16'h0000);
        $display("test window done");
        results();
    end
endmodule
`default_nettype wire
